/* File: hdl/pmc_defines.svh */
// Purpose: constants of the mode control block
// Assumes: 125 MHz system clock
// Notes: counts derive from times in ns
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_CLK_MHZ 125
`define PMC_INIT_NS 2000
`define PMC_REP_NS 800
`define PMC_SYNC_NS 48
`define PMC_INIT_CYC ((`PMC_INIT_NS*`PMC_CLK_MHZ+999)/1000)
`define PMC_REP_CYC ((`PMC_REP_NS*`PMC_CLK_MHZ+999)/1000)
`define PMC_SYNC_CYC ((`PMC_SYNC_NS*`PMC_CLK_MHZ+999)/1000)

// factory set: framed driver, no flow ctl, break mon, clear rx, 250
`define PMC_PARAM_DEFAULT 16'h1fd0
`define PMC_RX_LIMIT_MIN 8'h01
`define PMC_RX_LIMIT_MAX 8'hfa

`define PMC_CLASS_JOB 8'h05
`define PMC_NUM_MODE 8'h02
`define PMC_CLASS_ABORT 8'h1e
`define PMC_NUM_ABORT 8'h0d
`define PMC_CLASS_DIAG 8'h30
`define PMC_STATUS_OK 16'h0000

`endif

/* File: hdl/pmc_pkg.sv */
// Purpose: types of the mode control block
// Assumes: nothing
// Notes: field layout of the parameter set is packed msb first
package pmc_pkg;

    typedef enum logic [2:0]
    {
        MODE_STOP = 3'b001,
        MODE_REPARAM = 3'b010,
        MODE_RUN = 3'b100
    } pmc_mode_e;

    typedef enum logic [1:0]
    {
        DRV_FRAMED = 2'b00,
        DRV_PLAIN = 2'b01,
        DRV_PRINTER = 2'b10,
        DRV_BAD = 2'b11
    } pmc_drv_e;

    typedef enum logic [1:0]
    {
        JOB_NONE = 2'b00,
        JOB_SEND = 2'b01,
        JOB_RECV = 2'b10,
        JOB_PRINT = 2'b11
    } pmc_job_e;

    typedef struct packed
    {
        pmc_drv_e driver;
        logic flow_ctl;
        logic break_mon;
        logic clr_rx;
        logic [7:0] rx_limit;
        logic [2:0] spare;
    } pmc_param_s;

    typedef struct packed
    {
        logic [7:0] ev_class;
        logic [7:0] ev_num;
    } pmc_status_s;

endpackage

/* File: hdl/pmc_mode_ctrl.sv */
// Purpose: operating mode, startup and host transition control
// Assumes: host and link strobes synchronous to clk_sys_in
// Notes: rx frames are counted here, payload lives elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"

// Operation
// - in stop no driver runs; every host job gets a negative acknowledge
// - stop persists until the stop cause has gone
// - re-parameterisation initialises driver with fault lamp lit throughout
// - warm restart flushes frames, cancels host jobs, restarts host link
// - re-parameterisation ends in run, which serves jobs and partner frames
// - power-on loads factory parameters and starts with the framed driver
// - a delivered parameter set replaces the one in use
// - host stop aborts host transfers both ways, then reconnects
// - quiet drivers finish sending; plain driver receives until full
// - re-parameterise only when delivered parameters differ
// - no job runs before startup synchronisation with host finishes
// - a job cut by host stop reports abort after restart
// - link send starts only after the whole host frame arrived
// - option clears rx buffer at host start, else keeps 1..250 frames
// - frame cut by host stop is delivered again when kept
// - raise diagnostic alarm with four bytes of information
// - alarm lights fault lamp; events and errors enter diagnostic buffer
// - send and receive lamps show link activity
// - fault lamp lit at power-on, on faults and re-parameterisation
// - break lights fault lamp if monitored, and the receive lamp
// - status word holds event class and number in separate bytes
module pmc_mode_ctrl
    import pmc_pkg::*;
#(
    parameter int TX_DEPTH = 64,
    parameter int DIAG_DEPTH = 16
)
(
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // host mode and parameters
    input wire logic host_run_in,
    input wire logic param_valid_in,
    input wire pmc_param_s param_data_in,
    // host jobs
    input wire logic job_req_in,
    input wire pmc_job_e job_kind_in,
    input wire logic host_wr_in,
    input wire logic [7:0] host_wr_byte_in,
    input wire logic host_wr_last_in,
    input wire logic host_rd_ack_in,
    output logic job_done_out,
    output logic job_err_out,
    output pmc_status_s job_status_out,
    output logic host_rx_frame_out,
    // serial link
    output logic link_tx_valid_out,
    output logic [7:0] link_tx_byte_out,
    output logic link_tx_last_out,
    input wire logic link_tx_ready_in,
    input wire logic link_rx_valid_in,
    input wire logic link_rx_last_in,
    input wire logic line_break_in,
    // faults, lamps, diagnostics
    input wire logic hw_fault_in,
    input wire logic fw_error_in,
    input wire logic [$clog2(DIAG_DEPTH)-1:0] diag_rd_idx_in,
    output logic group_fault_lamp_out,
    output logic tx_lamp_out,
    output logic rx_lamp_out,
    output logic diag_alarm_out,
    output logic [31:0] diag_info_out,
    output logic [15:0] diag_rd_data_out,
    output logic [$clog2(DIAG_DEPTH)-1:0] diag_wr_ptr_out,
    output pmc_mode_e mode_out
);

    localparam int TW = $clog2(TX_DEPTH);
    localparam int DW = $clog2(DIAG_DEPTH);

    function automatic logic par_ok(input pmc_param_s p);
        par_ok = p.driver != DRV_BAD && p.rx_limit >= `PMC_RX_LIMIT_MIN
            && p.rx_limit <= `PMC_RX_LIMIT_MAX;
    endfunction

    pmc_mode_e mode_ff, nxt_mode;
    logic init_ff, par_err_ff, par_chg_ff, host_run_q_ff, synced_ff;
    logic [15:0] tmr_ff;
    logic [15:0] sync_ff;
    pmc_param_s act_par_ff;
    logic pend_ff, abort_snd_ff, abort_rcv_ff;
    pmc_job_e pend_kind_ff;
    logic [7:0] tx_mem [TX_DEPTH];
    logic [TW-1:0] tx_wcnt_ff, tx_len_ff, tx_rcnt_ff;
    logic tx_fill_ff, tx_busy_ff, rx_act_ff, rx_xfer_ff;
    logic [7:0] rx_cnt_ff;
    logic [15:0] dbuf [DIAG_DEPTH];
    logic [3:0] err_q_ff;
    logic stop_cause, enter_rep, host_stop, host_start, quiet;
    logic exec, is_snd, rej, abt, go_snd, go_rcv, tx_done, rx_done;
    logic rx_take, alarm;
    logic [3:0] err_vec;

    assign stop_cause = par_err_ff | (line_break_in & act_par_ff.break_mon);
    assign host_stop = host_run_q_ff & ~host_run_in;
    assign host_start = ~host_run_q_ff & host_run_in;
    assign quiet = (act_par_ff.driver == DRV_PLAIN
        || act_par_ff.driver == DRV_PRINTER) && !act_par_ff.flow_ctl;
    assign is_snd = pend_kind_ff != JOB_RECV;
    assign exec = pend_ff & synced_ff & host_run_in & ~tx_fill_ff
        & ~tx_busy_ff & ~rx_xfer_ff;
    assign rej = exec & (mode_ff != MODE_RUN);
    assign abt = exec & ~rej & (is_snd ? abort_snd_ff : abort_rcv_ff);
    assign go_snd = exec & ~rej & ~abt & is_snd;
    assign go_rcv = exec & ~rej & ~abt & ~is_snd & (rx_cnt_ff != 8'h00);
    assign tx_done = tx_busy_ff & link_tx_valid_out & link_tx_ready_in
        & link_tx_last_out;
    assign rx_done = rx_xfer_ff & host_rd_ack_in & host_run_in;
    assign err_vec = {hw_fault_in, fw_error_in, par_err_ff,
        line_break_in & act_par_ff.break_mon};
    assign alarm = |(err_vec & ~err_q_ff);
    assign enter_rep = nxt_mode == MODE_REPARAM && mode_ff != MODE_REPARAM;
    assign mode_out = mode_ff;
    assign host_rx_frame_out = rx_xfer_ff;

    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            MODE_REPARAM:
                if (tmr_ff == 16'h0000)
                    nxt_mode = stop_cause ? MODE_STOP : MODE_RUN;
            MODE_RUN:
                if (stop_cause)
                    nxt_mode = MODE_STOP;
                else if (par_chg_ff)
                    nxt_mode = MODE_REPARAM;
            MODE_STOP:
                if (!stop_cause)
                    nxt_mode = MODE_REPARAM;
            default:
                nxt_mode = MODE_STOP;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mode_ff <= MODE_REPARAM;
            init_ff <= 1'b1;
            tmr_ff <= 16'(`PMC_INIT_CYC);
        end
        else if (clk_en_in)
        begin
            mode_ff <= nxt_mode;
            if (init_ff && tmr_ff == 16'h0000)
                init_ff <= 1'b0;
            if (enter_rep)
                tmr_ff <= 16'(`PMC_REP_CYC);
            else if (tmr_ff != 16'h0000)
                tmr_ff <= tmr_ff - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            act_par_ff <= `PMC_PARAM_DEFAULT;
            par_err_ff <= 1'b0;
            par_chg_ff <= 1'b0;
        end
        else if (clk_en_in)
        begin
            par_chg_ff <= 1'b0;
            if (param_valid_in && !par_ok(param_data_in))
                par_err_ff <= 1'b1;
            else if (param_valid_in)
            begin
                par_err_ff <= 1'b0;
                if (param_data_in != act_par_ff)
                begin
                    act_par_ff <= param_data_in;
                    par_chg_ff <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            host_run_q_ff <= 1'b0;
            synced_ff <= 1'b0;
            sync_ff <= 16'(`PMC_SYNC_CYC);
        end
        else if (clk_en_in)
        begin
            host_run_q_ff <= host_run_in;
            if (host_start || host_stop || enter_rep)
            begin
                synced_ff <= 1'b0;
                sync_ff <= 16'(`PMC_SYNC_CYC);
            end
            else if (host_run_in && sync_ff != 16'h0000)
                sync_ff <= sync_ff - 16'h0001;
            else if (host_run_in)
                synced_ff <= 1'b1;
        end
    end

    // jobs are held, not lost, until sync ends
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pend_ff <= 1'b0;
            pend_kind_ff <= JOB_NONE;
            abort_snd_ff <= 1'b0;
            abort_rcv_ff <= 1'b0;
            job_done_out <= 1'b0;
            job_err_out <= 1'b0;
            job_status_out <= `PMC_STATUS_OK;
        end
        else if (clk_en_in)
        begin
            job_done_out <= rej | abt | tx_done | rx_done
                | (enter_rep & pend_ff);
            job_err_out <= rej | abt | (enter_rep & pend_ff);
            if (rej)
                job_status_out <= {`PMC_CLASS_JOB, `PMC_NUM_MODE};
            else if (abt || (enter_rep && pend_ff))
                job_status_out <= {`PMC_CLASS_ABORT, `PMC_NUM_ABORT};
            else if (tx_done || rx_done)
                job_status_out <= `PMC_STATUS_OK;
            if (enter_rep || rej || abt || tx_done || rx_done)
                pend_ff <= 1'b0;
            else if (job_req_in && !pend_ff && job_kind_in != JOB_NONE)
            begin
                pend_ff <= 1'b1;
                pend_kind_ff <= job_kind_in;
            end
            if (host_stop && tx_fill_ff)
                abort_snd_ff <= 1'b1;
            else if (abt && is_snd)
                abort_snd_ff <= 1'b0;
            if (host_stop && rx_xfer_ff)
                abort_rcv_ff <= 1'b1;
            else if (abt && !is_snd)
                abort_rcv_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (clk_en_in && tx_fill_ff && host_wr_in)
            tx_mem[tx_wcnt_ff] <= host_wr_byte_in;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tx_fill_ff <= 1'b0;
            tx_busy_ff <= 1'b0;
            tx_wcnt_ff <= '0;
            tx_len_ff <= '0;
            tx_rcnt_ff <= '0;
            link_tx_valid_out <= 1'b0;
            link_tx_byte_out <= 8'h00;
            link_tx_last_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (enter_rep || mode_ff == MODE_STOP
                || (host_stop && !quiet))
            begin
                tx_fill_ff <= 1'b0;
                tx_busy_ff <= 1'b0;
                link_tx_valid_out <= 1'b0;
            end
            else if (host_stop)
                tx_fill_ff <= 1'b0;
            else if (go_snd)
            begin
                tx_fill_ff <= 1'b1;
                tx_wcnt_ff <= '0;
            end
            else if (tx_fill_ff && host_wr_in)
            begin
                if (tx_wcnt_ff != TW'(TX_DEPTH - 1))
                    tx_wcnt_ff <= tx_wcnt_ff + 1'b1;
                if (host_wr_last_in)
                begin
                    tx_fill_ff <= 1'b0;
                    tx_busy_ff <= 1'b1;
                    tx_len_ff <= tx_wcnt_ff;
                    tx_rcnt_ff <= '0;
                end
            end
            else if (tx_busy_ff && !link_tx_valid_out)
            begin
                link_tx_valid_out <= 1'b1;
                link_tx_byte_out <= tx_mem[tx_rcnt_ff];
                link_tx_last_out <= tx_rcnt_ff == tx_len_ff;
                tx_rcnt_ff <= tx_rcnt_ff + 1'b1;
            end
            else if (link_tx_valid_out && link_tx_ready_in)
            begin
                link_tx_valid_out <= 1'b0;
                if (link_tx_last_out)
                    tx_busy_ff <= 1'b0;
            end
        end
    end

    // plain driver keeps receiving while host stopped
    assign rx_take = link_rx_valid_in && mode_ff == MODE_RUN
        && (host_run_in || act_par_ff.driver == DRV_PLAIN)
        && rx_cnt_ff < act_par_ff.rx_limit;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_cnt_ff <= 8'h00;
            rx_act_ff <= 1'b0;
            rx_xfer_ff <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (enter_rep)
            begin
                rx_cnt_ff <= 8'h00;
                rx_act_ff <= 1'b0;
            end
            else if (host_start && act_par_ff.clr_rx)
                rx_cnt_ff <= 8'h00;
            else
            begin
                rx_cnt_ff <= rx_cnt_ff + 8'(rx_take & link_rx_last_in)
                    - 8'(rx_done);
                if (rx_take)
                    rx_act_ff <= !link_rx_last_in;
            end
            // cut frame stays queued for resend
            if (enter_rep || host_stop || rx_done)
                rx_xfer_ff <= 1'b0;
            else if (go_rcv)
                rx_xfer_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            err_q_ff <= 4'h0;
            diag_alarm_out <= 1'b0;
            diag_info_out <= 32'h0000_0000;
            diag_wr_ptr_out <= '0;
            diag_rd_data_out <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            err_q_ff <= err_vec;
            diag_alarm_out <= alarm;
            if (alarm)
                diag_info_out <= {16'h0000, 5'h00, mode_ff, 4'h0, err_vec};
            diag_wr_ptr_out <= diag_wr_ptr_out + DW'(alarm)
                + DW'(job_done_out);
            diag_rd_data_out <= dbuf[diag_rd_idx_in];
        end
    end

    // both events may land together, so two slots are written
    always_ff @(posedge clk_sys_in)
    begin
        if (clk_en_in && alarm)
            dbuf[diag_wr_ptr_out] <= {`PMC_CLASS_DIAG, 4'h0, err_vec};
        if (clk_en_in && job_done_out)
            dbuf[diag_wr_ptr_out + DW'(alarm)] <= job_status_out;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            group_fault_lamp_out <= 1'b1;
            tx_lamp_out <= 1'b0;
            rx_lamp_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            group_fault_lamp_out <= init_ff | (mode_ff == MODE_REPARAM)
                | (|err_vec);
            tx_lamp_out <= tx_busy_ff;
            rx_lamp_out <= rx_act_ff | line_break_in;
        end
    end

    default clocking cb @(posedge clk_sys_in iff clk_en_in);
    endclocking
    default disable iff (!resetn_in);

    property p_stop_nak;
        rej |=> job_done_out && job_err_out
            && job_status_out == 16'h0502;
    endproperty
    a_stop_nak: assert property (p_stop_nak)
        else $error("stop job not refused");

    property p_stop_hold;
        mode_ff == MODE_STOP && stop_cause |=> mode_ff == MODE_STOP;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("left stop with cause present");

    property p_rep_lamp;
        mode_ff == MODE_REPARAM |=> group_fault_lamp_out;
    endproperty
    a_rep_lamp: assert property (p_rep_lamp)
        else $error("fault lamp dark in reparam");

    property p_flush;
        enter_rep |=> rx_cnt_ff == 8'h00 && !tx_busy_ff && !pend_ff;
    endproperty
    a_flush: assert property (p_flush)
        else $error("warm restart left frames");

    property p_rep_run;
        mode_ff == MODE_REPARAM && tmr_ff == 16'h0000 && !stop_cause
            |=> mode_ff == MODE_RUN;
    endproperty
    a_rep_run: assert property (p_rep_run)
        else $error("reparam did not end in run");

    property p_same_par;
        param_valid_in && param_data_in == act_par_ff |=> !par_chg_ff;
    endproperty
    a_same_par: assert property (p_same_par)
        else $error("reparam on unchanged set");

    property p_sync;
        !synced_ff |=> !$rose(tx_fill_ff) && !$rose(rx_xfer_ff);
    endproperty
    a_sync: assert property (p_sync)
        else $error("job ran before sync");

    property p_abort;
        abt |=> job_err_out && job_status_out == 16'h1e0d;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort status wrong");

    property p_no_early_tx;
        tx_fill_ff |-> !link_tx_valid_out;
    endproperty
    a_no_early_tx: assert property (p_no_early_tx)
        else $error("link send before host frame complete");

    property p_rx_limit;
        rx_cnt_ff <= act_par_ff.rx_limit || $changed(act_par_ff)
            || $past(par_chg_ff);
    endproperty
    a_rx_limit: assert property (p_rx_limit)
        else $error("rx store above limit");

    property p_brk;
        line_break_in && act_par_ff.break_mon
            |=> group_fault_lamp_out && rx_lamp_out;
    endproperty
    a_brk: assert property (p_brk)
        else $error("break lamps not lit");

endmodule
`default_nettype wire

/* File: tb/pmc_link_partner.sv */
// Purpose: serial link partner model
// Assumes: one clock shared with the block
// Notes: rx frames are strobes only, no payload
`timescale 1ns/1ps
`default_nettype none
module pmc_link_partner
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // bench control
    input wire logic stall_in,
    input wire logic go_in,
    // link side
    output logic tx_ready_out,
    output logic rx_valid_out,
    output logic rx_last_out
);
    logic [1:0] left_ff;
    // stalling keeps ready low so a held valid is exercised
    assign tx_ready_out = ~stall_in;
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            left_ff <= 2'h0;
        else if (go_in)
            left_ff <= 2'h3;
        else if (left_ff != 2'h0)
            left_ff <= left_ff - 2'h1;
    end
    assign rx_valid_out = (left_ff != 2'h0);
    assign rx_last_out = (left_ff == 2'h1);
endmodule
`default_nettype wire

/* File: tb/pmc_mode_ctrl_tb_top.sv */
// Purpose: self-checking bench of the mode control block
// Assumes: 125 MHz clock, partner model on the link
// Notes: of the frame payload only the first sent byte is compared, else only its timing
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_mode_ctrl_tb_top;
    import pmc_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic host_run_in = 1'b0;
    logic param_valid_in = 1'b0;
    pmc_param_s param_data_in = `PMC_PARAM_DEFAULT;
    logic job_req_in = 1'b0;
    pmc_job_e job_kind_in = JOB_NONE;
    logic host_wr_in = 1'b0;
    logic [7:0] host_wr_byte_in = 8'h00;
    logic host_wr_last_in = 1'b0;
    logic host_rd_ack_in = 1'b0;
    logic line_break_in = 1'b0;
    logic hw_fault_in = 1'b0;
    logic fw_error_in = 1'b0;
    // slot 2 holds the first aborted send's status entry
    logic [3:0] diag_rd_idx_in = 4'h2;
    logic stall = 1'b0;
    logic go = 1'b0;
    logic job_done_out, job_err_out, host_rx_frame_out;
    logic link_tx_valid_out, link_tx_last_out, link_tx_ready_in;
    logic link_rx_valid_in, link_rx_last_in;
    logic group_fault_lamp_out, tx_lamp_out, rx_lamp_out;
    logic diag_alarm_out;
    logic [31:0] diag_info_out;
    logic [15:0] diag_rd_data_out;
    logic [3:0] diag_wr_ptr_out;
    logic [7:0] link_tx_byte_out;
    pmc_status_s job_status_out;
    pmc_mode_e mode_out;
    int errors = 0;
    int n_compared = 0;

    always #4 clk_sys_in = ~clk_sys_in;

    pmc_mode_ctrl uut
    (
        .clk_sys_in, .resetn_in, .clk_en_in, .host_run_in,
        .param_valid_in, .param_data_in, .job_req_in, .job_kind_in,
        .host_wr_in, .host_wr_byte_in, .host_wr_last_in,
        .host_rd_ack_in, .job_done_out, .job_err_out, .job_status_out,
        .host_rx_frame_out, .link_tx_valid_out, .link_tx_byte_out,
        .link_tx_last_out, .link_tx_ready_in, .link_rx_valid_in,
        .link_rx_last_in, .line_break_in, .hw_fault_in, .fw_error_in,
        .diag_rd_idx_in, .group_fault_lamp_out, .tx_lamp_out,
        .rx_lamp_out, .diag_alarm_out, .diag_info_out,
        .diag_rd_data_out, .diag_wr_ptr_out, .mode_out
    );

    pmc_link_partner peer
    (
        .clk_sys_in, .resetn_in, .stall_in(stall), .go_in(go),
        .tx_ready_out(link_tx_ready_in),
        .rx_valid_out(link_rx_valid_in),
        .rx_last_out(link_rx_last_in)
    );

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // bounded waits look just after an edge, once updates have landed
    task automatic wait_hi(ref logic s, input int lim, input string what);
        int i;
        #1;
        for (i = 0; i < lim && s !== 1'b1; i++)
        begin
            @(posedge clk_sys_in);
            #1;
        end
        chk(what, 16'h1, {15'h0, s});
    endtask

    task automatic wait_mode(input pmc_mode_e m, input int lim);
        int i;
        #1;
        for (i = 0; i < lim && mode_out !== m; i++)
        begin
            @(posedge clk_sys_in);
            #1;
        end
        chk("mode", {13'h0, m}, {13'h0, mode_out});
    endtask

    task automatic wait_done(input logic err, input logic [15:0] st);
        wait_hi(job_done_out, 60, "done");
        chk("err", {15'h0, err}, {15'h0, job_err_out});
        chk("status", st, job_status_out);
    endtask

    task automatic job(input pmc_job_e k);
        @(posedge clk_sys_in);
        job_req_in <= 1'b1;
        job_kind_in <= k;
        @(posedge clk_sys_in);
        job_req_in <= 1'b0;
    endtask

    task automatic put_param(input logic [15:0] p);
        @(posedge clk_sys_in);
        param_data_in <= p;
        param_valid_in <= 1'b1;
        @(posedge clk_sys_in);
        param_valid_in <= 1'b0;
    endtask

    // link must stay quiet while the host frame is still arriving
    task automatic host_bytes(input int n, input logic fin);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge clk_sys_in);
            host_wr_in <= 1'b1;
            host_wr_byte_in <= 8'(8'ha0 + i);
            host_wr_last_in <= fin && (i == n - 1);
        end
        @(posedge clk_sys_in);
        host_wr_in <= 1'b0;
        host_wr_last_in <= 1'b0;
        #1;
        chk("tx_valid", 16'h0, {15'h0, link_tx_valid_out});
    endtask

    initial
    begin
        #(8 * 3000);
        errors++;
        summarize();
    end

    initial
    begin
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("mode", {13'h0, MODE_REPARAM}, {13'h0, mode_out});
        chk("lamp", 16'h1, {15'h0, group_fault_lamp_out});
        @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        wait_mode(MODE_RUN, `PMC_INIT_CYC + 10);
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("lamp", 16'h0, {15'h0, group_fault_lamp_out});
        job(JOB_RECV);
        host_run_in <= 1'b1;
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("rx_frame", 16'h0, {15'h0, host_rx_frame_out});
        wait_hi(host_rx_frame_out, 30, "rx_frame");
        @(posedge clk_sys_in);
        host_rd_ack_in <= 1'b1;
        @(posedge clk_sys_in);
        host_rd_ack_in <= 1'b0;
        wait_done(1'b0, `PMC_STATUS_OK);
        job(JOB_SEND);
        stall <= 1'b1;
        host_bytes(4, 1'b1);
        wait_hi(link_tx_valid_out, 10, "tx_valid");
        chk("tx_lamp", 16'h1, {15'h0, tx_lamp_out});
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("tx_valid", 16'h1, {15'h0, link_tx_valid_out});
        chk("tx_byte", 16'h00a0, {8'h0, link_tx_byte_out});
        chk("tx_last", 16'h0, {15'h0, link_tx_last_out});
        @(posedge clk_sys_in);
        stall <= 1'b0;
        wait_done(1'b0, `PMC_STATUS_OK);
        job(JOB_SEND);
        host_bytes(2, 1'b0);
        @(posedge clk_sys_in);
        host_run_in <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        host_run_in <= 1'b1;
        wait_done(1'b1, {`PMC_CLASS_ABORT, `PMC_NUM_ABORT});
        // monitored break stops the block and lights both lamps
        @(posedge clk_sys_in);
        line_break_in <= 1'b1;
        wait_mode(MODE_STOP, 4);
        chk("lamp", 16'h1, {15'h0, group_fault_lamp_out});
        chk("rx_lamp", 16'h1, {15'h0, rx_lamp_out});
        @(posedge clk_sys_in);
        line_break_in <= 1'b0;
        wait_mode(MODE_RUN, `PMC_REP_CYC + 10);
        put_param({DRV_BAD, 3'h0, 8'h05, 3'h0});
        wait_mode(MODE_STOP, 6);
        chk("lamp", 16'h1, {15'h0, group_fault_lamp_out});
        job(JOB_SEND);
        wait_done(1'b1, {`PMC_CLASS_JOB, `PMC_NUM_MODE});
        put_param({DRV_PLAIN, 3'h0, 8'h05, 3'h0});
        wait_mode(MODE_REPARAM, 6);
        @(posedge clk_sys_in);
        #1;
        chk("lamp", 16'h1, {15'h0, group_fault_lamp_out});
        wait_mode(MODE_RUN, `PMC_REP_CYC + 10);
        put_param({DRV_PLAIN, 3'h0, 8'h05, 3'h0});
        repeat (6) @(posedge clk_sys_in);
        #1;
        chk("mode", {13'h0, MODE_RUN}, {13'h0, mode_out});
        // rx store kept across host stop, cut frame offered again
        job(JOB_RECV);
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        wait_hi(host_rx_frame_out, 10, "rx_frame");
        @(posedge clk_sys_in);
        host_run_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        host_run_in <= 1'b1;
        wait_done(1'b1, {`PMC_CLASS_ABORT, `PMC_NUM_ABORT});
        job(JOB_RECV);
        wait_hi(host_rx_frame_out, 20, "rx_frame");
        @(posedge clk_sys_in);
        host_rd_ack_in <= 1'b1;
        @(posedge clk_sys_in);
        host_rd_ack_in <= 1'b0;
        wait_done(1'b0, `PMC_STATUS_OK);
        @(posedge clk_sys_in);
        line_break_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("rx_lamp", 16'h1, {15'h0, rx_lamp_out});
        chk("lamp", 16'h0, {15'h0, group_fault_lamp_out});
        @(posedge clk_sys_in);
        line_break_in <= 1'b0;
        hw_fault_in <= 1'b1;
        wait_hi(diag_alarm_out, 3, "alarm");
        chk("lamp", 16'h1, {15'h0, group_fault_lamp_out});
        chk("diag_info", 16'h0408, diag_info_out[15:0]);
        // nine entries: six job results and three alarms
        chk("diag_ptr", 16'h0009, {12'h0, diag_wr_ptr_out});
        chk("diag_rd", 16'h1e0d, diag_rd_data_out);
        summarize();
    end
endmodule
`default_nettype wire
